// ---- rtl/dc_motor_pwm_controller.sv ----
// Summary of operation
// - Period register, word 0, 32 bits
// - High-time register, word 1, 32 bits
// - Control bit 0 starts or stops
// - Control bit 1 selects direction
// - Duty cycle sets motor speed
`timescale 1ns/100ps

module dc_motor_pwm_controller
	import pwm_motor_pkg::*;
#(
	parameter int WIDTH = DATA_W
) (
	input  wire logic              mclk,           // System clock, 250 MHz
	input  wire logic              reset_n,        // Async reset, active low
	input  wire logic [ADDR_W-1:0] reg_addr,       // Register word index
	input  wire logic              reg_write,      // Write strobe
	input  wire logic              reg_read,       // Read strobe
	input  wire logic [WIDTH-1:0]  reg_wdata,      // Write data
	output logic      [WIDTH-1:0]  reg_rdata,      // Read data
	output logic                   reg_rvalid,     // Read data valid pulse
	output logic                   motor_drive_a,  // Bridge input A, forward
	output logic                   motor_drive_b,  // Bridge input B, backward
	output logic                   motor_forward,  // Applied direction
	output logic                   pwm_active      // Generator running
);

	logic [WIDTH-1:0] pwm_period_ticks_reg;
	logic [WIDTH-1:0] pwm_high_ticks_reg;
	logic             run_reg;
	logic             dir_reg;
	logic [WIDTH-1:0] period_act_reg;
	logic [WIDTH-1:0] high_act_reg;
	logic             dir_act_reg;
	run_state_t       state_reg;
	run_state_t       state_next;
	logic             wr_period;
	logic             wr_high;
	logic             wr_ctrl;
	logic             cnt_enable;
	logic             cnt_wrap;
	logic             cnt_level;
	logic             load_shadow;
	logic [WIDTH-1:0] rdata_next;

	function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] idx);
		hit = (addr == idx);
	endfunction

	always_comb begin
		wr_period = reg_write && hit(reg_addr, IDX_PERIOD);
		wr_high   = reg_write && hit(reg_addr, IDX_HIGH);
		wr_ctrl   = reg_write && hit(reg_addr, IDX_CTRL);
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pwm_period_ticks_reg <= PERIOD_RESET;
		end else if (wr_period) begin
			pwm_period_ticks_reg <= reg_wdata;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pwm_high_ticks_reg <= HIGH_RESET;
		end else if (wr_high) begin
			pwm_high_ticks_reg <= reg_wdata;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			run_reg <= RUN_RESET;
		end else if (wr_ctrl) begin
			run_reg <= reg_wdata[CTRL_RUN_BIT];
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			dir_reg <= DIR_RESET;
		end else if (wr_ctrl) begin
			dir_reg <= reg_wdata[CTRL_DIR_BIT];
		end
	end

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (run_reg) begin
					state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!run_reg) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	assign cnt_enable  = (state_reg == ST_RUN);
	// New counts only at a cycle edge, so no runt pulse reaches the bridge
	assign load_shadow = ((state_reg == ST_IDLE) && run_reg) || cnt_wrap;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			period_act_reg <= PERIOD_RESET;
			high_act_reg   <= HIGH_RESET;
		end else if (load_shadow) begin
			period_act_reg <= pwm_period_ticks_reg;
			high_act_reg   <= pwm_high_ticks_reg;
		end
	end

	// Direction swaps at a cycle edge to spare the bridge a mid-pulse reversal
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			dir_act_reg <= DIR_RESET;
		end else if (load_shadow) begin
			dir_act_reg <= dir_reg;
		end
	end

	pwm_tick_counter #(
		.WIDTH     (WIDTH)
	) u_counter (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.enable    (cnt_enable),
		.period    (period_act_reg),
		.high_time (high_act_reg),
		.wrap      (cnt_wrap),
		.level     (cnt_level)
	);

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			motor_drive_a <= 1'b0;
			motor_drive_b <= 1'b0;
		end else begin
			motor_drive_a <= cnt_enable && cnt_level && dir_act_reg;
			motor_drive_b <= cnt_enable && cnt_level && !dir_act_reg;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			motor_forward <= DIR_RESET;
			pwm_active    <= 1'b0;
		end else begin
			motor_forward <= dir_act_reg;
			pwm_active    <= cnt_enable;
		end
	end

	always_comb begin
		rdata_next = UNMAPPED_VALUE;
		unique case (reg_addr)
			IDX_PERIOD: begin
				rdata_next = pwm_period_ticks_reg;
			end
			IDX_HIGH: begin
				rdata_next = pwm_high_ticks_reg;
			end
			IDX_CTRL: begin
				rdata_next[CTRL_RUN_BIT] = run_reg;
				rdata_next[CTRL_DIR_BIT] = dir_reg;
				// Bit 2 reports the generator state
				rdata_next[CTRL_ACT_BIT] = cnt_enable;
			end
			default: begin
				rdata_next = UNMAPPED_VALUE;
			end
		endcase
	end

	// One cycle read latency; data holds until the next read
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= '0;
		end else if (reg_read) begin
			reg_rdata <= rdata_next;
		end
	end

	// One pulse per read strobe, no wait states
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_read;
		end
	end

endmodule // dc_motor_pwm_controller

// ---- rtl/pwm_motor_pkg.sv ----
package pwm_motor_pkg;

	// Register map, word indices on the register port
	localparam int          ADDR_W         = 2;
	localparam int          DATA_W         = 32;
	localparam logic [1:0]  IDX_PERIOD     = 2'h0;
	localparam logic [1:0]  IDX_HIGH       = 2'h1;
	localparam logic [1:0]  IDX_CTRL       = 2'h2;

	// Control register fields
	localparam int          CTRL_RUN_BIT   = 0;
	localparam int          CTRL_DIR_BIT   = 1;
	localparam int          CTRL_ACT_BIT   = 2;

	// Reset values
	localparam logic [31:0] PERIOD_RESET   = 32'h0000_0000;
	localparam logic [31:0] HIGH_RESET     = 32'h0000_0000;
	localparam logic        RUN_RESET      = 1'b0;
	localparam logic        DIR_RESET      = 1'b0;
	localparam logic [31:0] UNMAPPED_VALUE = 32'h0000_0000;

	// Run state machine
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN  = 2'b10
	} run_state_t;

endpackage

// ---- rtl/pwm_tick_counter.sv ----
`timescale 1ns/100ps

module pwm_tick_counter
	import pwm_motor_pkg::*;
#(
	parameter int WIDTH = DATA_W
) (
	input  wire logic             mclk,       // System clock
	input  wire logic             reset_n,    // Async reset, active low
	input  wire logic             enable,     // Count while high, clear when low
	input  wire logic [WIDTH-1:0] period,     // Ticks per cycle
	input  wire logic [WIDTH-1:0] high_time,  // High ticks per cycle
	output logic                  wrap,       // Last tick of the cycle
	output logic                  level       // Registered pulse level
);

	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;

	always_comb begin
		wrap       = enable && ((period == '0) || (count_reg >= period - WIDTH'(1)));
		count_next = wrap ? '0 : count_reg + WIDTH'(1);
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			count_reg <= '0;
		end else if (!enable) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			level <= 1'b0;
		end else begin
			level <= enable && (period != '0) && (count_reg < high_time);
		end
	end

endmodule // pwm_tick_counter

// ---- test/hbridge_model.sv ----
`timescale 1ns/100ps
module hbridge_model (
	input  wire logic        mclk, // Clock
	input  wire logic        clr,  // Clear counts
	input  wire logic        in_a, // Forward input
	input  wire logic        in_b, // Backward input
	output logic      [31:0] hi_a, // Forward ticks
	output logic      [31:0] hi_b  // Backward ticks
);
	always_ff @(posedge mclk) begin
		if (clr) begin
			hi_a <= 32'h0;
			hi_b <= 32'h0;
		end else begin
			hi_a <= hi_a + {31'h0, in_a & ~in_b};
			hi_b <= hi_b + {31'h0, in_b & ~in_a};
		end
	end
endmodule // hbridge_model

// ---- test/pwm_ctrl_sva.sv ----
`timescale 1ns/100ps
module pwm_ctrl_sva
	import pwm_motor_pkg::*;
#(parameter int WIDTH = DATA_W) (
	input wire logic [ADDR_W-1:0] reg_addr,      // Index
	input wire logic              mclk,          // Clock
	input wire logic              reset_n,       // Reset
	input wire logic              reg_write,     // Write
	input wire logic              reg_read,      // Read
	input wire logic [WIDTH-1:0]  reg_wdata,     // Wdata
	input wire logic [WIDTH-1:0]  reg_rdata,     // Rdata
	input wire logic              reg_rvalid,    // Valid
	input wire logic              motor_drive_a, // Pin A
	input wire logic              motor_drive_b, // Pin B
	input wire logic              motor_forward, // Dir
	input wire logic              pwm_active     // Running
);
	logic [WIDTH-1:0] per_reg;
	logic [WIDTH-1:0] hi_reg;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Shadow copies of written counts
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			per_reg <= PERIOD_RESET;
			hi_reg <= HIGH_RESET;
		end else if (reg_write && reg_addr == IDX_PERIOD) begin
			per_reg <= reg_wdata;
		end else if (reg_write && reg_addr == IDX_HIGH) begin
			hi_reg <= reg_wdata;
		end
	end
	period_readback_a: assert property (reg_read && reg_addr == IDX_PERIOD |=> reg_rvalid && reg_rdata == per_reg)
		else $error("period readback wrong");
	high_readback_a: assert property (reg_read && reg_addr == IDX_HIGH |=> reg_rvalid && reg_rdata == hi_reg)
		else $error("high readback wrong");
	unmapped_read_a: assert property (reg_read && reg_addr == 2'h3 |=> reg_rdata == UNMAPPED_VALUE)
		else $error("unmapped read not zero");
	run_start_a: assert property (reg_write && reg_addr == IDX_CTRL && reg_wdata[0] |-> ##[1:3] pwm_active)
		else $error("start not taken");
	run_stop_a: assert property (reg_write && reg_addr == IDX_CTRL && !reg_wdata[0] |-> ##[1:3] !pwm_active)
		else $error("stop not taken");
	one_side_a: assert property (!(motor_drive_a && motor_drive_b))
		else $error("both bridge inputs high");
	fwd_pin_a: assert property (motor_drive_a && $past(motor_drive_a) |-> motor_forward)
		else $error("pin A pulses while backward");
	idle_low_a: assert property (motor_drive_a || motor_drive_b |-> pwm_active)
		else $error("drive while stopped");
endmodule // pwm_ctrl_sva
bind dc_motor_pwm_controller pwm_ctrl_sva #(.WIDTH(WIDTH)) u_sva (.mclk, .reset_n, .reg_addr, .reg_write,
	.reg_read, .reg_wdata, .reg_rdata, .reg_rvalid, .motor_drive_a, .motor_drive_b, .motor_forward, .pwm_active);

// ---- test/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
	import pwm_motor_pkg::*;
	logic        mclk, reset_n, reg_write, reg_read, clr, reg_rvalid;
	logic        motor_drive_a, motor_drive_b, motor_forward, pwm_active;
	logic [1:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, hi_a, hi_b;
	int          errors, samples_checked;
	dc_motor_pwm_controller u_dut (.mclk, .reset_n, .reg_addr, .reg_write, .reg_read, .reg_wdata, .reg_rdata,
		.reg_rvalid, .motor_drive_a, .motor_drive_b, .motor_forward, .pwm_active);
	hbridge_model u_bridge (.mclk, .clr, .in_a(motor_drive_a), .in_b(motor_drive_b), .hi_a, .hi_b);
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Edge gap first, so a strobe is never set twice in one step
	// single-word write
	task automatic wr(input logic [1:0] a, input logic [31:0] d);
		@(posedge mclk) #1;
		{reg_addr, reg_wdata, reg_write} = {a, d, 1'b1};
		@(posedge mclk) #1;
		reg_write = 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, input logic [31:0] exp);
		@(posedge mclk) #1;
		{reg_addr, reg_read} = {a, 1'b1};
		@(posedge mclk) #1;
		reg_read = 1'b0;
		chk({31'h0, reg_rvalid}, 32'h1);
		chk(reg_rdata, exp);
	endtask
	// Whole periods, so the phase does not matter
	task automatic meas(input logic [31:0] ea, input logic [31:0] eb);
		@(posedge mclk) #1 clr = 1'b1;
		@(posedge mclk) #1 clr = 1'b0;
		repeat (100) @(posedge mclk);
		#1;
		chk(hi_a, ea);
		chk(hi_b, eb);
	endtask
	task automatic t_regs;
		rd(IDX_PERIOD, PERIOD_RESET);
		rd(IDX_HIGH, HIGH_RESET);
		wr(IDX_PERIOD, 32'hffff_ffff);
		rd(IDX_PERIOD, 32'hffff_ffff);
		wr(IDX_PERIOD, 32'h0000_000a);
		rd(IDX_PERIOD, 32'h0000_000a);
		wr(IDX_HIGH, 32'h0000_0003);
		rd(IDX_HIGH, 32'h0000_0003);
		wr(2'h3, 32'h0000_0055);
		rd(2'h3, UNMAPPED_VALUE);
		rd(IDX_CTRL, 32'h0);
	endtask
	task automatic t_back;
		wr(IDX_CTRL, 32'hffff_fff9);
		repeat (20) @(posedge mclk);
		meas(32'h0, 32'h1e);
		chk({31'h0, motor_forward}, 32'h0);
		chk({31'h0, pwm_active}, 32'h1);
		rd(IDX_CTRL, 32'h0000_0005);
	endtask
	task automatic t_fwd;
		wr(IDX_HIGH, 32'h0000_000a);
		wr(IDX_CTRL, 32'h0000_0003);
		repeat (20) @(posedge mclk);
		meas(32'h64, 32'h0);
		chk({31'h0, motor_forward}, 32'h1);
	endtask
	task automatic t_stop;
		wr(IDX_CTRL, 32'h0000_0002);
		repeat (5) @(posedge mclk);
		meas(32'h0, 32'h0);
		chk({31'h0, pwm_active}, 32'h0);
		rd(IDX_CTRL, 32'h0000_0002);
	endtask
	// Mid-run reset, then a start with a zero period
	task automatic t_reset;
		wr(IDX_CTRL, 32'h0000_0001);
		repeat (20) @(posedge mclk);
		#1 chk({31'h0, motor_drive_b}, 32'h1);
		reset_n = 1'b0;
		#1 chk({30'h0, motor_drive_b, pwm_active}, 32'h0);
		@(posedge mclk) #1 reset_n = 1'b1;
		rd(IDX_PERIOD, PERIOD_RESET);
		rd(IDX_HIGH, HIGH_RESET);
		rd(IDX_CTRL, 32'h0);
		wr(IDX_CTRL, 32'h0000_0003);
		meas(32'h0, 32'h0);
		rd(IDX_CTRL, 32'h0000_0007);
	endtask
	task automatic complete_run;
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		{reset_n, reg_write, reg_read, clr, reg_addr, reg_wdata} = 38'h0;
		{errors, samples_checked} = 64'h0;
		repeat (2) @(posedge mclk);
		#1 reset_n = 1'b1;
		t_regs;
		t_back;
		t_fwd;
		t_stop;
		t_reset;
		complete_run;
	end
	// About 520 cycles expected
	initial begin
		#8000;
		errors++;
		complete_run;
	end
endmodule // tb_top
